// ---- logic/rshc_pkg.sv ----
// register map, field positions, reset values and timing constants of the
// reference switchover and holdover controller.
// assumes a 32-bit apb slave with byte addresses and one word per register.
package rshc_pkg;
    // apb geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DIV_W = 10;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_REFCFG = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MISC = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PWR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DIV_PRI = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_DIV_SEC = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h1C;

    // refcfg fields
    localparam int B_VCXO_CFG_LO = 0;
    localparam int VCXO_CFG_W = 2;
    localparam int B_PRI_SE_PD = 2;
    localparam int B_SEC_SE_PD = 3;
    localparam int B_PRI_CMOS = 5;
    localparam int B_SEC_CMOS = 6;
    localparam logic [7:0] REFCFG_WMASK = 8'h6F;

    // misc fields
    localparam int B_MODE_LO = 0;
    localparam int MODE_W = 2;
    localparam int B_MAN_SEL = 2;
    localparam int B_CP_MID = 6;
    localparam int B_SEC_INDEP = 7;
    localparam logic [7:0] MISC_WMASK = 8'hC7;

    // power field
    localparam int B_LOOP_PD = 2;

    // status fields
    localparam int B_ST_PRI_OK = 0;
    localparam int B_ST_SEC_OK = 1;
    localparam int B_ST_ACT_SEC = 2;
    localparam int B_ST_HOLD = 3;
    localparam int B_ST_CP_TRI = 4;
    localparam int B_ST_CP_MID = 5;

    // interrupt events
    localparam int IRQ_W = 5;
    localparam int E_SWITCH = 0;
    localparam int E_HOLD_IN = 1;
    localparam int E_HOLD_OUT = 2;
    localparam int E_PRI_LOST = 3;
    localparam int E_SEC_LOST = 4;

    // reset values
    localparam logic [7:0] REFCFG_RST = 8'h00;
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RST = 10'h001;
    localparam logic [DIV_W-1:0] DIV_MIN = 10'h001;
    localparam logic [DIV_W-1:0] DIV_MAX = 10'h3FF;

    // absence timeout in vcxo clock periods
    localparam int MON_TIMEOUT = 1024;
    localparam int MON_W = 16;

    // switchover modes
    typedef enum logic [MODE_W-1:0] {
        MODE_MAN_REG = 2'h0,
        MODE_MAN_PIN = 2'h1,
        MODE_AUTO_REV = 2'h2,
        MODE_AUTO_NONREV = 2'h3
    } rshc_mode_e;

    // switchover states, gray along primary -> secondary -> holdover
    typedef enum logic [1:0] {
        ST_PRI = 2'b00,
        ST_SEC = 2'b01,
        ST_HOLD = 2'b11
    } rshc_state_e;
endpackage : rshc_pkg

// ---- logic/rshc_prescaler.sv ----
// integer prescaler: one output pulse per div input pulses.
// assumes in_pulse is a single-cycle pulse on pclk; div 0 acts as 1.
`timescale 1ns/1ps
module rshc_prescaler #(
    parameter int DIV_W = 10
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // division
    input wire logic [DIV_W-1:0] div,
    input wire logic in_pulse,
    output logic out_pulse
);
    logic [DIV_W-1:0] cnt_reg;

    generate
        if (DIV_W < 1) begin : g_bad
            $error("rshc_prescaler: DIV_W must be at least 1");
        end
    endgenerate

    // count input pulses; the wrap emits one output pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            out_pulse <= 1'b0;
        end else if (ce) begin
            out_pulse <= 1'b0;
            if (in_pulse) begin
                if (cnt_reg + 1'b1 >= div) begin
                    cnt_reg <= '0;
                    out_pulse <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end
endmodule : rshc_prescaler

// ---- logic/rshc_ref_monitor.sv ----
// presence monitor for one prescaled reference, timed in vcxo periods.
// assumes both inputs are single-cycle pulses on pclk.
`timescale 1ns/1ps
module rshc_ref_monitor #(
    parameter int TIMEOUT = 1024,
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // events
    input wire logic ref_pulse,
    input wire logic vcxo_pulse,
    output logic present
);
    logic [CNT_W-1:0] gap_reg;

    generate
        if (TIMEOUT < 2 || TIMEOUT >= (1 << CNT_W)) begin : g_bad
            $error("rshc_ref_monitor: TIMEOUT out of range for CNT_W");
        end
    endgenerate

    // any prescaled edge restarts the gap count and marks presence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_reg <= '0;
            present <= 1'b0;
        end else if (ce) begin
            if (ref_pulse) begin
                gap_reg <= '0;
                present <= 1'b1;
            end else if (vcxo_pulse) begin
                if (gap_reg >= CNT_W'(TIMEOUT - 1)) begin
                    present <= 1'b0;
                end else begin
                    gap_reg <= gap_reg + 1'b1;
                end
            end
        end
    end
endmodule : rshc_ref_monitor

// ---- logic/rshc_ctrl.sv ----
// Notes on behaviour
// - each reference divided by 1 to 1023
// - monitor judges presence after the prescaler
// - manual select by register or pin
// - auto: primary lost, secondary present, switch
// - nonrevertive: stay on secondary until it fails
// - revertive: back to primary once present
// - no reference: holdover, pump tristated
// - leave holdover when a reference returns
// - option: pump driven to mid-supply in holdover
// - secondary uses primary divider unless independent
// - per-input bit selects single-ended cmos receiver
// - differential receiver off unless selected and powered
// - single-ended buffer off by loop, bit, differential
// - loop power-down also powers down vcxo receiver
// - two-bit vcxo receiver control in refcfg
// - auto: single present reference becomes active
//
// top of the input-loop reference switchover and holdover controller.
// assumes reference and vcxo pins are asynchronous to pclk and much slower
// than it; registers are reached by an apb master on pclk.
`timescale 1ns/1ps
module rshc_ctrl #(
    parameter int MON_TIMEOUT = rshc_pkg::MON_TIMEOUT,
    parameter int DIV_W = rshc_pkg::DIV_W
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rshc_pkg::ADDR_W-1:0] paddr,
    input wire logic [rshc_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [rshc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // reference and vcxo pins
    input wire logic primary_ref,
    input wire logic secondary_ref,
    input wire logic vcxo_clock_input,
    input wire logic ref_select_pin,
    // switchover and charge pump control
    output logic active_is_secondary,
    output logic holdover,
    output logic cp_tristate,
    output logic cp_midsupply,
    output logic loop_resync,
    // receiver power and configuration
    output logic primary_diff_pd,
    output logic secondary_diff_pd,
    output logic primary_se_pd,
    output logic secondary_se_pd,
    output logic vcxo_rx_pd,
    output logic [rshc_pkg::VCXO_CFG_W-1:0] vcxo_rx_cfg,
    // interrupt
    output logic irq
);
    import rshc_pkg::*;

    localparam int NPIN = 3;
    localparam int P_PRI = 0;
    localparam int P_SEC = 1;
    localparam int P_VCXO = 2;

    generate
        if (DIV_W != rshc_pkg::DIV_W) begin : g_bad_div
            $error("rshc_ctrl: divider width must match the register field");
        end
    endgenerate

    // software registers
    logic [7:0] refcfg_reg;
    logic [7:0] misc_reg;
    logic loop_pd_reg;
    logic [DIV_W-1:0] div_pri_reg;
    logic [DIV_W-1:0] div_sec_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;

    // pin conditioning
    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic [NPIN-1:0] sync3_reg;
    logic [NPIN-1:0] level_reg;
    logic [NPIN-1:0] rise;
    logic sel_s1_reg;
    logic sel_s2_reg;
    logic sel_s3_reg;
    logic sel_level_reg;

    // divided references and presence
    logic [DIV_W-1:0] div_sec_eff;
    logic pri_div_pulse;
    logic sec_div_pulse;
    logic pri_ok;
    logic sec_ok;
    logic pri_ok_d_reg;
    logic sec_ok_d_reg;

    // switchover state
    rshc_state_e state_reg;
    rshc_state_e state_next;
    rshc_mode_e mode;
    logic man_want_sec;
    logic [IRQ_W-1:0] irq_set;

    // apb decode
    logic wr_ok;
    logic rd_ok;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] wmask;

    // true when the bus address selects the given register word
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
        reg_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction : reg_hit

    // true for any mapped register
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = reg_hit(a, OFF_REFCFG) || reg_hit(a, OFF_MISC)
            || reg_hit(a, OFF_PWR) || reg_hit(a, OFF_DIV_PRI)
            || reg_hit(a, OFF_DIV_SEC) || reg_hit(a, OFF_STATUS)
            || reg_hit(a, OFF_IRQ_STAT) || reg_hit(a, OFF_IRQ_MASK);
    endfunction : addr_mapped

    assign pin_in = {vcxo_clock_input, secondary_ref, primary_ref};

    // three-stage synchronisers; a level only moves when stages two and three
    // agree, which rejects a single-sample glitch from a slow edge
    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                    sync3_reg[i] <= 1'b0;
                    level_reg[i] <= 1'b0;
                end else if (ce) begin
                    sync1_reg[i] <= pin_in[i];
                    sync2_reg[i] <= sync1_reg[i];
                    sync3_reg[i] <= sync2_reg[i];
                    if (sync2_reg[i] == sync3_reg[i]) begin
                        level_reg[i] <= sync3_reg[i];
                    end
                end
            end
            assign rise[i] = ce && (sync2_reg[i] == sync3_reg[i])
                && sync3_reg[i] && !level_reg[i];
        end
    endgenerate

    // reference-select pin, same conditioning as the clock pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_s1_reg <= 1'b0;
            sel_s2_reg <= 1'b0;
            sel_s3_reg <= 1'b0;
            sel_level_reg <= 1'b0;
        end else if (ce) begin
            sel_s1_reg <= ref_select_pin;
            sel_s2_reg <= sel_s1_reg;
            sel_s3_reg <= sel_s2_reg;
            if (sel_s2_reg == sel_s3_reg) begin
                sel_level_reg <= sel_s3_reg;
            end
        end
    end

    // secondary divider follows the primary unless made independent
    assign div_sec_eff = misc_reg[B_SEC_INDEP] ? div_sec_reg : div_pri_reg;

    rshc_prescaler #(.DIV_W(DIV_W)) u_div_pri (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .div(div_pri_reg),
        .in_pulse(rise[P_PRI]),
        .out_pulse(pri_div_pulse)
    );

    rshc_prescaler #(.DIV_W(DIV_W)) u_div_sec (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .div(div_sec_eff),
        .in_pulse(rise[P_SEC]),
        .out_pulse(sec_div_pulse)
    );

    // monitors look only at the divided references, timed by the undivided vcxo edge
    rshc_ref_monitor #(.TIMEOUT(MON_TIMEOUT), .CNT_W(MON_W)) u_mon_pri (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .ref_pulse(pri_div_pulse),
        .vcxo_pulse(rise[P_VCXO]),
        .present(pri_ok)
    );

    rshc_ref_monitor #(.TIMEOUT(MON_TIMEOUT), .CNT_W(MON_W)) u_mon_sec (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .ref_pulse(sec_div_pulse),
        .vcxo_pulse(rise[P_VCXO]),
        .present(sec_ok)
    );

    assign mode = rshc_mode_e'(misc_reg[B_MODE_LO +: MODE_W]);
    // manual choice comes from the register bit or from the pin
    assign man_want_sec = (mode == MODE_MAN_PIN) ? sel_level_reg
        : misc_reg[B_MAN_SEL];

    // switchover decision, driven by monitor status
    always_comb begin
        state_next = state_reg;
        if (!pri_ok && !sec_ok) begin
            state_next = ST_HOLD;
        end else if (mode == MODE_MAN_REG || mode == MODE_MAN_PIN) begin
            state_next = man_want_sec ? ST_SEC : ST_PRI;
        end else begin
            case (state_reg)
                ST_PRI: begin
                    if (!pri_ok) begin
                        state_next = ST_SEC;
                    end
                end
                ST_SEC: begin
                    if (!sec_ok) begin
                        state_next = ST_PRI;
                    end else if (pri_ok && mode == MODE_AUTO_REV) begin
                        state_next = ST_PRI;
                    end
                end
                default: begin
                    // leaving holdover: primary wins when present, else secondary
                    state_next = pri_ok ? ST_PRI : ST_SEC;
                end
            endcase
        end
    end

    // state and loop-side outputs; the pump mode follows holdover and the mid-supply bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_HOLD;
            active_is_secondary <= 1'b0;
            holdover <= 1'b1;
            cp_tristate <= 1'b1;
            cp_midsupply <= 1'b0;
            loop_resync <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            active_is_secondary <= (state_next == ST_SEC);
            holdover <= (state_next == ST_HOLD);
            cp_tristate <= (state_next == ST_HOLD) && !misc_reg[B_CP_MID];
            cp_midsupply <= (state_next == ST_HOLD) && misc_reg[B_CP_MID];
            loop_resync <= (state_next != state_reg) && (state_next != ST_HOLD);
        end
    end

    // receiver power gating, registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_diff_pd <= 1'b1;
            secondary_diff_pd <= 1'b1;
            primary_se_pd <= 1'b1;
            secondary_se_pd <= 1'b1;
            vcxo_rx_pd <= 1'b0;
            vcxo_rx_cfg <= '0;
        end else if (ce) begin
            primary_diff_pd <= refcfg_reg[B_PRI_CMOS] || loop_pd_reg;
            secondary_diff_pd <= refcfg_reg[B_SEC_CMOS] || loop_pd_reg;
            primary_se_pd <= loop_pd_reg || refcfg_reg[B_PRI_SE_PD]
                || !refcfg_reg[B_PRI_CMOS];
            secondary_se_pd <= loop_pd_reg || refcfg_reg[B_SEC_SE_PD]
                || !refcfg_reg[B_SEC_CMOS];
            vcxo_rx_pd <= loop_pd_reg;
            vcxo_rx_cfg <= refcfg_reg[B_VCXO_CFG_LO +: VCXO_CFG_W];
        end
    end

    // event detection for the interrupt status
    always_comb begin
        irq_set = '0;
        irq_set[E_SWITCH] = (state_next != state_reg) && (state_next != ST_HOLD)
            && (state_reg != ST_HOLD);
        irq_set[E_HOLD_IN] = (state_next == ST_HOLD) && (state_reg != ST_HOLD);
        irq_set[E_HOLD_OUT] = (state_next != ST_HOLD) && (state_reg == ST_HOLD);
        irq_set[E_PRI_LOST] = pri_ok_d_reg && !pri_ok;
        irq_set[E_SEC_LOST] = sec_ok_d_reg && !sec_ok;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri_ok_d_reg <= 1'b0;
            sec_ok_d_reg <= 1'b0;
        end else if (ce) begin
            pri_ok_d_reg <= pri_ok;
            sec_ok_d_reg <= sec_ok;
        end
    end

    // apb: one wait state, so pready and prdata both come from flops
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    assign rd_ok = psel && penable && !pready && !pwrite;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_mapped(paddr);
        end
    end

    // read mux; reserved and unmapped bits read as zero
    always_comb begin
        rd_word = '0;
        if (reg_hit(paddr, OFF_REFCFG)) begin
            rd_word[7:0] = refcfg_reg;
        end else if (reg_hit(paddr, OFF_MISC)) begin
            rd_word[7:0] = misc_reg;
        end else if (reg_hit(paddr, OFF_PWR)) begin
            rd_word[B_LOOP_PD] = loop_pd_reg;
        end else if (reg_hit(paddr, OFF_DIV_PRI)) begin
            rd_word[DIV_W-1:0] = div_pri_reg;
        end else if (reg_hit(paddr, OFF_DIV_SEC)) begin
            rd_word[DIV_W-1:0] = div_sec_reg;
        end else if (reg_hit(paddr, OFF_STATUS)) begin
            rd_word[B_ST_PRI_OK] = pri_ok;
            rd_word[B_ST_SEC_OK] = sec_ok;
            rd_word[B_ST_ACT_SEC] = active_is_secondary;
            rd_word[B_ST_HOLD] = holdover;
            rd_word[B_ST_CP_TRI] = cp_tristate;
            rd_word[B_ST_CP_MID] = cp_midsupply;
        end else if (reg_hit(paddr, OFF_IRQ_STAT)) begin
            rd_word[IRQ_W-1:0] = irq_stat_reg;
        end else if (reg_hit(paddr, OFF_IRQ_MASK)) begin
            rd_word[IRQ_W-1:0] = irq_mask_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (ce && rd_ok) begin
            prdata <= rd_word;
        end
    end

    // configuration writes honour byte strobes; loop power-down is software's
    // to keep clear when the loop is bypassed, hardware does not force it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refcfg_reg <= REFCFG_RST;
            misc_reg <= MISC_RST;
            loop_pd_reg <= 1'b0;
        end else if (ce && wr_ok && pstrb[0]) begin
            if (reg_hit(paddr, OFF_REFCFG)) begin
                refcfg_reg <= pwdata[7:0] & REFCFG_WMASK;
            end else if (reg_hit(paddr, OFF_MISC)) begin
                misc_reg <= pwdata[7:0] & MISC_WMASK;
            end else if (reg_hit(paddr, OFF_PWR)) begin
                loop_pd_reg <= pwdata[B_LOOP_PD];
            end
        end
    end

    // divider writes; zero is clamped to one, the lowest legal ratio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_pri_reg <= DIV_RST;
            div_sec_reg <= DIV_RST;
        end else if (ce && wr_ok && pstrb[0] && pstrb[1]) begin
            if (reg_hit(paddr, OFF_DIV_PRI)) begin
                div_pri_reg <= (pwdata[DIV_W-1:0] < DIV_MIN) ? DIV_MIN
                    : pwdata[DIV_W-1:0];
            end else if (reg_hit(paddr, OFF_DIV_SEC)) begin
                div_sec_reg <= (pwdata[DIV_W-1:0] < DIV_MIN) ? DIV_MIN
                    : pwdata[DIV_W-1:0];
            end
        end
    end

    // sticky status: a new event in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            if (wr_ok && reg_hit(paddr, OFF_IRQ_STAT)) begin
                irq_stat_reg <= (irq_stat_reg & ~(pwdata[IRQ_W-1:0]
                    & wmask[IRQ_W-1:0])) | irq_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
            if (wr_ok && pstrb[0] && reg_hit(paddr, OFF_IRQ_MASK)) begin
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end
endmodule : rshc_ctrl

// ---- bench/rshc_ref_model.sv ----
// two reference sources and a vcxo, all paced by the bench clock
// assumes pclk from the bench; every level lasts several pclk periods
`timescale 1ns/1ps
module rshc_ref_model (
    // clock and source enables
    input wire logic pclk,
    input wire logic en_pri,
    input wire logic en_sec,
    // pins
    output logic primary_ref,
    output logic secondary_ref,
    output logic vcxo_clock_input
);
    int cnt = 0;
    initial {primary_ref, secondary_ref, vcxo_clock_input} = 3'h0;
    // a disabled source stands still; the vcxo never stops, so holdover keeps a clock
    always @(posedge pclk) begin
        cnt <= cnt + 1;
        if (cnt % 4 == 3) vcxo_clock_input <= ~vcxo_clock_input;
        if (cnt % 5 == 4 && en_pri) primary_ref <= ~primary_ref;
        if (cnt % 7 == 6 && en_sec) secondary_ref <= ~secondary_ref;
    end
endmodule : rshc_ref_model

// ---- bench/rshc_ctrl_monitor.sv ----
// port relations of the switchover controller
// assumes ce is held high
`timescale 1ns/1ps
module rshc_ctrl_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // loop control
    input wire logic active_is_secondary,
    input wire logic holdover,
    input wire logic cp_tristate,
    input wire logic cp_midsupply,
    input wire logic loop_resync,
    // receiver power
    input wire logic primary_diff_pd,
    input wire logic secondary_diff_pd,
    input wire logic primary_se_pd,
    input wire logic secondary_se_pd,
    input wire logic vcxo_rx_pd
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pump parking and reference choice
    property p_cp; (cp_tristate | cp_midsupply) == holdover; endproperty
    a_cp: assert property (p_cp) else $error("pump off holdover");
    property p_ex; !(cp_tristate && cp_midsupply); endproperty
    a_ex: assert property (p_ex) else $error("pump tristate and mid");
    property p_ha; holdover |-> !active_is_secondary; endproperty
    a_ha: assert property (p_ha) else $error("active in holdover");
    // a single-ended buffer is off while its differential receiver runs
    property p_se; (primary_diff_pd | primary_se_pd) & (secondary_diff_pd | secondary_se_pd);
    endproperty
    a_se: assert property (p_se) else $error("both receivers on");
    property p_vp; vcxo_rx_pd |-> primary_diff_pd & secondary_diff_pd & primary_se_pd;
    endproperty
    a_vp: assert property (p_vp) else $error("rx on at loop pd");
    // resync pulse on a switch to secondary and on leaving holdover
    property p_rs; $rose(active_is_secondary) |-> loop_resync; endproperty
    a_rs: assert property (p_rs) else $error("no resync on switch");
    property p_rh; $fell(holdover) |-> loop_resync; endproperty
    a_rh: assert property (p_rh) else $error("no resync on exit");
    property p_rp; loop_resync |=> !loop_resync; endproperty
    a_rp: assert property (p_rp) else $error("resync too long");
endmodule : rshc_ctrl_monitor

// ---- bench/rshc_ctrl_tb.sv ----
// self-checking bench of the switchover and holdover controller
// assumes the reference model drives the pins; ce and pstrb stay high
`timescale 1ns/1ps
module rshc_ctrl_tb;
    import rshc_pkg::*;
    localparam int TO = 8;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin = 0, b, err;
    logic en_pri = 0, en_sec = 0, pready, pslverr, pri, sec, vcx, act, hold, tri_o, mid;
    logic rsy, irq, pdp, pds, psp, pss, vpd;
    logic [1:0] vcfg;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int failures = 0, check_count = 0, cyc = 0, cfg, lpd;
    // free-running bench clock
    initial forever #2 pclk = ~pclk;
    rshc_ref_model u_ref (.pclk(pclk), .en_pri(en_pri), .en_sec(en_sec),
        .primary_ref(pri), .secondary_ref(sec), .vcxo_clock_input(vcx));
    rshc_ctrl #(.MON_TIMEOUT(TO)) u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_ref(pri), .secondary_ref(sec), .vcxo_clock_input(vcx),
        .ref_select_pin(pin), .active_is_secondary(act), .holdover(hold),
        .cp_tristate(tri_o), .cp_midsupply(mid), .loop_resync(rsy),
        .primary_diff_pd(pdp), .secondary_diff_pd(pds), .primary_se_pd(psp),
        .secondary_se_pd(pss), .vcxo_rx_pd(vpd), .vcxo_rx_cfg(vcfg), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // apb transfer; the answer is taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // sources change, then the monitors get well past their timeout
    task automatic sw(input logic ep, input logic es, input logic a, input logic h);
        {en_pri, en_sec} <= {ep, es};
        repeat (24 * TO) @(posedge pclk);
        chk({act, hold}, {a, h});
    endtask : sw
    function automatic logic [6:0] pd_exp(input int c, input int l);
        return {c[5] | l[0], c[6] | l[0], l[0] | c[2] | !c[5], l[0] | c[3] | !c[6], l[0], c[1:0]};
    endfunction : pd_exp
    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // cycle ceiling in case a handshake hangs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            report_and_stop();
        end
    end
    // main sequence
    initial begin
        void'($urandom(78208));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({hold, tri_o, mid, act, irq}, 5'h18);
        apb(0, OFF_DIV_PRI, 0);
        chk(rd, 32'h1);
        apb(1, OFF_DIV_PRI, 32'h3FF);
        apb(0, OFF_DIV_PRI, 0);
        chk(rd, 32'h3FF);
        apb(1, OFF_DIV_PRI, 32'h1);
        apb(1, OFF_MISC, 32'h2);
        sw(0, 1, 1, 0);
        sw(1, 1, 0, 0);
        apb(1, OFF_IRQ_MASK, 32'h1F);
        apb(1, OFF_IRQ_STAT, 32'h1F);
        sw(0, 1, 1, 0);
        chk(irq, 1'b1);
        apb(1, OFF_IRQ_MASK, 32'h0);
        apb(0, OFF_IRQ_STAT, 0);
        chk({irq, rd[30:0]}, 32'h09);
        apb(1, OFF_IRQ_STAT, 32'h1F);
        apb(1, OFF_IRQ_MASK, 32'h1F);
        chk(irq, 1'b0);
        sw(1, 1, 0, 0);
        apb(1, OFF_MISC, 32'h3);
        sw(0, 1, 1, 0);
        sw(1, 1, 1, 0);
        sw(1, 0, 0, 0);
        sw(0, 0, 0, 1);
        chk({tri_o, mid}, 2'b10);
        apb(1, OFF_MISC, 32'h43);
        apb(0, OFF_STATUS, 0);
        chk(rd, 32'h28);
        sw(0, 1, 1, 0);
        apb(1, OFF_MISC, 32'h4);
        sw(1, 1, 1, 0);
        apb(1, OFF_MISC, 32'h0);
        sw(1, 1, 0, 0);
        apb(1, OFF_MISC, 32'h1);
        repeat (4) begin
            b = $urandom;
            pin <= b;
            sw(1, 1, b, 0);
        end
        repeat (8) begin
            cfg = $urandom & 32'h6F;
            lpd = $urandom % 2;
            apb(1, OFF_REFCFG, cfg);
            apb(1, OFF_PWR, lpd << 2);
            repeat (2) @(posedge pclk);
            chk({pdp, pds, psp, pss, vpd, vcfg}, pd_exp(cfg, lpd));
        end
        apb(1, OFF_PWR, 0);
        apb(1, OFF_DIV_SEC, 32'h3FF);
        apb(1, OFF_MISC, 32'h2);
        sw(1, 1, 0, 0);
        apb(0, OFF_STATUS, 0);
        chk(rd, 32'h03);
        apb(1, OFF_MISC, 32'h82);
        sw(1, 1, 0, 0);
        apb(0, OFF_STATUS, 0);
        chk(rd, 32'h01);
        apb(0, 8'h20, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        report_and_stop();
    end
endmodule : rshc_ctrl_tb
bind rshc_ctrl rshc_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .active_is_secondary(active_is_secondary), .holdover(holdover),
    .cp_tristate(cp_tristate), .cp_midsupply(cp_midsupply), .loop_resync(loop_resync),
    .primary_diff_pd(primary_diff_pd), .secondary_diff_pd(secondary_diff_pd),
    .primary_se_pd(primary_se_pd), .secondary_se_pd(secondary_se_pd),
    .vcxo_rx_pd(vcxo_rx_pd));
